// ===== pei_event_irq.sv
// phy event interrupt unit: apb registers, event latching, interrupt pin, downshift config
`timescale 1ns/10ps

// Notes on behaviour
// - a status bit is set whenever its event occurred since the last status read.
// - events are recorded whatever the enables; enables only gate the interrupt.
// - autoneg error, speed change and duplex change latch in bits 15, 14, 13, cleared by read.
// - page received, autoneg done and link change latch in bits 12, 11, 10, cleared by read.
// - false carrier latches in bit 8 and crossover in bit 6; bits 9 and 7 read zero.
// - downshift event, sleep change and wake packet latch in bits 5, 4, 3, cleared by read.
// - mac interface error, polarity change and jabber latch in bits 2, 1, 0, cleared by read.
// - enable bits 2, 1, 0 are read-write and reset to zero.
// - the interrupt asserts only for pending events whose enable is set.
// - enables for bits 15 to 3 mirror status positions and reset to zero.
// - config bit 13 set (reset) makes the pin active low, clear makes it active high.
// - attempt count at 11:10 is read-only, reset code 10, codes select 1, 2, 4, 8 attempts.
// - downshift enable at bit 9 is read-write and resets to zero or the strap value.
// - enhanced mode bit 8 is read-write and resets to one.
// - config bits 15:14 ignore writes and read zero.
module pei_event_irq
  import pei_pkg::*;
#(
  parameter bit STRAP_SENSITIVE = 1'b0
) (
  // clock and reset
  sys_clk,
  srst,
  // apb slave
  paddr,
  psel,
  penable,
  pwrite,
  pwdata,
  prdata,
  pready,
  pslverr,
  // event pulses from the phy
  eventIn,
  // strap for downshift enable
  downshiftStrap,
  // configuration outputs
  downshiftEnable,
  downshiftEnhancedEnable,
  downshiftTo10mEnable,
  downshiftAttempts,
  // interrupt
  irqLevel,
  irqPin
);
  input  wire logic        sys_clk;
  input  wire logic        srst;
  input  wire logic [11:0] paddr;
  input  wire logic        psel;
  input  wire logic        penable;
  input  wire logic        pwrite;
  input  wire logic [31:0] pwdata;
  output logic      [31:0] prdata;
  output logic             pready;
  output logic             pslverr;
  input  wire logic [15:0] eventIn;
  input  wire logic        downshiftStrap;
  output logic             downshiftEnable;
  output logic             downshiftEnhancedEnable;
  output logic             downshiftTo10mEnable;
  output logic      [3:0]  downshiftAttempts;
  output logic             irqLevel;
  output logic             irqPin;

  //////////////////////////////////////////////////////////////////////////////
  // register state
  logic [15:0] enable_q;
  logic        irqActiveLow_q;
  logic        dsEnable_q;
  logic        dsEnhanced_q;
  logic        dsTo10m_q;
  logic        strapTaken_q;
  logic [31:0] prdata_q;
  logic        irqPin_q;
  logic [15:0] statusFlags;

  // address decode
  wire         access      = psel & penable;
  wire         hitEnable   = (paddr == ENABLE_CONTROL_ADDR);
  wire         hitStatus   = (paddr == EVENT_STATUS_ADDR);
  wire         hitConfig   = (paddr == CONFIG_ADDR);
  wire         mapped      = hitEnable | hitStatus | hitConfig;
  wire         wrEnable    = access & pwrite & hitEnable;
  wire         wrConfig    = access & pwrite & hitConfig;
  wire         statusRead  = access & ~pwrite & hitStatus;

  // config read image: 15:14 and 12, 7 read zero, 5:0 keep their fixed value
  wire  [15:0] configView  = {2'h0, irqActiveLow_q, 1'b0, ATTEMPT_COUNT_RESET,
                              dsEnable_q, dsEnhanced_q, 1'b0, dsTo10m_q,
                              CONFIG_LOW_RESERVED};
  wire  [15:0] readMux     = hitEnable ? enable_q :
                             hitStatus ? statusFlags :
                             hitConfig ? configView : 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // event flags, cleared by a status read
  pei_event_latch #(
    .WIDTH (16)
  ) u_latch (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .eventIn  (eventIn),
    .clearAll (statusRead),
    .flags    (statusFlags)
  );

  //////////////////////////////////////////////////////////////////////////////
  // enable register: reserved bits 9 and 7 stay zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      enable_q <= ENABLE_RESET;
    end else if (wrEnable) begin
      enable_q <= pwdata[15:0] & EVENT_MASK;
    end
  end

  // configuration register; writes to reserved and read-only fields are dropped
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irqActiveLow_q <= IRQ_POL_RESET;
      dsEnhanced_q   <= ENH_RESET;
      dsTo10m_q      <= TO10M_RESET;
    end else if (wrConfig) begin
      irqActiveLow_q <= pwdata[IRQ_POLARITY_BIT];
      dsEnhanced_q   <= pwdata[DS_ENHANCED_BIT];
      dsTo10m_q      <= pwdata[DS_TO_10M_BIT];
    end
  end

  // downshift enable: the strap is caught at the first edge after reset release
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dsEnable_q   <= 1'b0;
      strapTaken_q <= 1'b0;
    end else if (wrConfig) begin
      dsEnable_q   <= pwdata[DS_ENABLE_BIT];
      strapTaken_q <= 1'b1;
    end else if (!strapTaken_q) begin
      dsEnable_q   <= STRAP_SENSITIVE & downshiftStrap;
      strapTaken_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb read data, registered at the edge that ends the setup phase
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_q <= {16'h0000, readMux};
    end
  end

  // zero-wait answer; unmapped addresses flag an error
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt: any pending enabled event, polarity per config
  assign irqLevel = |(statusFlags & enable_q);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irqPin_q <= IRQ_POL_RESET; // inactive for active-low reset polarity
    end else begin
      irqPin_q <= irqLevel ^ irqActiveLow_q;
    end
  end

  assign irqPin = irqPin_q;

  // downshift configuration outputs
  assign downshiftEnable         = dsEnable_q;
  assign downshiftEnhancedEnable = dsEnhanced_q;
  assign downshiftTo10mEnable    = dsTo10m_q;
  assign downshiftAttempts       = 4'h4; // code 10 selects four attempts

endmodule : pei_event_irq

// ===== pei_pkg.sv
// package: register map, field positions, reset values for the phy event interrupt unit
package pei_pkg;

  // register indices (printed offsets are not multiples of four: byte address is 4 x index)
  localparam logic [7:0]  ENABLE_CONTROL_IDX = 8'h12;
  localparam logic [7:0]  EVENT_STATUS_IDX   = 8'h13;
  localparam logic [7:0]  CONFIG_IDX         = 8'h14;
  localparam logic [11:0] ENABLE_CONTROL_ADDR = {2'h0, ENABLE_CONTROL_IDX, 2'h0};
  localparam logic [11:0] EVENT_STATUS_ADDR   = {2'h0, EVENT_STATUS_IDX, 2'h0};
  localparam logic [11:0] CONFIG_ADDR         = {2'h0, CONFIG_IDX, 2'h0};

  // event bit positions, shared by status and enable registers
  localparam int AUTONEG_ERROR_BIT  = 15;
  localparam int SPEED_CHANGE_BIT   = 14;
  localparam int DUPLEX_CHANGE_BIT  = 13;
  localparam int PAGE_RECEIVED_BIT  = 12;
  localparam int AUTONEG_DONE_BIT   = 11;
  localparam int LINK_CHANGE_BIT    = 10;
  localparam int FALSE_CARRIER_BIT  = 8;
  localparam int CROSSOVER_BIT      = 6;
  localparam int SPEED_OPT_BIT      = 5;
  localparam int SLEEP_CHANGE_BIT   = 4;
  localparam int WAKE_PACKET_BIT    = 3;
  localparam int MAC_IF_ERROR_BIT   = 2;
  localparam int POLARITY_BIT       = 1;
  localparam int JABBER_BIT         = 0;

  // implemented event bits (9 and 7 reserved, read zero)
  localparam logic [15:0] EVENT_MASK = 16'hfd7f;

  // configuration register fields
  localparam int IRQ_POLARITY_BIT    = 13;
  localparam int ATTEMPT_HI_BIT      = 11;
  localparam int ATTEMPT_LO_BIT      = 10;
  localparam int DS_ENABLE_BIT       = 9;
  localparam int DS_ENHANCED_BIT     = 8;
  localparam int DS_TO_10M_BIT       = 6;
  localparam logic [15:0] CONFIG_RW_MASK = 16'h2340;
  localparam logic [1:0]  ATTEMPT_COUNT_RESET = 2'h2;
  localparam logic [5:0]  CONFIG_LOW_RESERVED = 6'h07;

  // reset values
  localparam logic [15:0] ENABLE_RESET  = 16'h0000;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic        IRQ_POL_RESET = 1'b1;
  localparam logic        ENH_RESET     = 1'b1;
  localparam logic        TO10M_RESET   = 1'b1;

endpackage : pei_pkg

// ===== pei_event_latch.sv
// latched-high clear-on-read event flags
`timescale 1ns/10ps
module pei_event_latch
  import pei_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // event pulses and clear
  input  wire logic [WIDTH-1:0] eventIn,
  input  wire logic             clearAll,
  // latched flags
  output logic      [WIDTH-1:0] flags
);

  // elaboration-time guard: the flag map is fixed at sixteen positions
  if (WIDTH != 16) begin : g_bad_width
    $error("pei_event_latch: width must be 16");
  end

  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  // new events set regardless of enables; a set in the read cycle survives the clear
  assign flags_d = ((clearAll ? '0 : flags_q) | eventIn) & EVENT_MASK;

  //////////////////////////////////////////////////////////////////////////////
  // flag register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flags_q <= STATUS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule : pei_event_latch

// ===== pei_event_irq_checker.sv
// checker: port-level assertions for the phy event interrupt unit
`timescale 1ns/10ps
module pei_event_irq_checker
  import pei_pkg::*;
(
  // clock, reset and apb
  input wire logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // events and outputs
  input wire logic [15:0] eventIn,
  input wire logic        downshiftEnable, downshiftEnhancedEnable, downshiftTo10mEnable,
  input wire logic [3:0]  downshiftAttempts,
  input wire logic        irqLevel, irqPin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // access-phase decodes
  wire acc   = psel && penable;
  wire stRd  = acc && !pwrite && paddr == EVENT_STATUS_ADDR;
  wire cfgRd = acc && !pwrite && paddr == CONFIG_ADDR;
  wire cfgWr = acc && pwrite && paddr == CONFIG_ADDR;
  wire enWr  = acc && pwrite && paddr == ENABLE_CONTROL_ADDR;
  wire [2:0] cfgOut = {downshiftEnable, downshiftEnhancedEnable, downshiftTo10mEnable};
  ////////////////////////////////////////////////////////////////////////
  attempt_const_a: assert property (downshiftAttempts == 4'h4)
    else $error("attempt count not four");
  status_rsvd_a: assert property (stRd |-> !prdata[9] && !prdata[7])
    else $error("reserved status bit set");
  cfg_fields_a: assert property (cfgRd |-> prdata[15:14] == 2'h0 && prdata[11:10] == 2'h2)
    else $error("config read-only field wrong");
  irq_cause_a: assert property ($rose(irqLevel) |-> $past(eventIn != 16'h0) || $past(enWr))
    else $error("interrupt rose without cause");
  read_clear_a: assert property (stRd && eventIn == 16'h0 |=> !irqLevel)
    else $error("interrupt stayed after status read");
  pin_follow_a: assert property ($changed(irqPin) |->
      $past(irqLevel) != $past(irqLevel, 2) || $past(cfgWr, 2))
    else $error("interrupt pin moved alone");
  cfg_hold_a: assert property (!cfgWr |=> $stable(cfgOut))
    else $error("config changed without write");
  cfg_write_a: assert property (cfgWr |=> cfgOut == $past({pwdata[9], pwdata[8], pwdata[6]}))
    else $error("config write not taken");
  // main scenarios
  cover property ($rose(irqLevel));
  cover property (stRd);
  cover property (acc && pslverr);
endmodule : pei_event_irq_checker
bind pei_event_irq pei_event_irq_checker i_chk (.sys_clk(sys_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .eventIn(eventIn), .downshiftEnable(downshiftEnable),
  .downshiftEnhancedEnable(downshiftEnhancedEnable), .downshiftTo10mEnable(downshiftTo10mEnable),
  .downshiftAttempts(downshiftAttempts), .irqLevel(irqLevel), .irqPin(irqPin));

// ===== pei_event_src.sv
// partner model: phy event source giving event pulses one cycle after each request
`timescale 1ns/10ps
module pei_event_src (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // request and pulses
  input  wire logic [15:0] evReq,
  output logic      [15:0] eventIn
);
  // a request appears on eventIn one cycle later and lasts as long as the request
  always_ff @(posedge sys_clk) begin
    eventIn <= srst ? 16'h0 : evReq;
  end
endmodule : pei_event_src

// ===== tb.sv
// testbench: apb sequences against the phy event interrupt unit
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import pei_pkg::*;
  localparam logic [15:0] CFG_RST = {2'h0, IRQ_POL_RESET, 1'b0, ATTEMPT_COUNT_RESET, 1'b0,
                                     ENH_RESET, 1'b0, TO10M_RESET, CONFIG_LOW_RESERVED};
  logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr, slvErr;
  logic        dsEn, dsEnh, ds10, irqLevel, irqPin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] evReq, eventIn, q;
  logic [3:0]  dsAtt;
  int          failures = 0, check_count = 0, cyc = 0;
  pei_event_src i_src (.sys_clk(sys_clk), .srst(srst), .evReq(evReq), .eventIn(eventIn));
  pei_event_irq i_dut (.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eventIn(eventIn), .downshiftStrap(1'b0), .downshiftEnable(dsEn),
    .downshiftEnhancedEnable(dsEnh), .downshiftTo10mEnable(ds10),
    .downshiftAttempts(dsAtt), .irqLevel(irqLevel), .irqPin(irqPin));
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // one apb transfer; ev is pulsed so that it arrives in the access cycle
  task automatic apb(input logic [11:0] a, input logic w, input logic [15:0] d,
                     input logic [15:0] ev, output logic [15:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= {16'h0, d}; evReq <= ev;
    @(posedge sys_clk);
    penable <= 1'b1; evReq <= 16'h0;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    r = prdata[15:0];
    slvErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // pulse events, then wait until flag and pin have settled
  task automatic fire(input logic [15:0] ev);
    @(posedge sys_clk); evReq <= ev;
    @(posedge sys_clk); evReq <= 16'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : fire
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0; evReq = '0;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    apb(ENABLE_CONTROL_ADDR, 0, 0, 0, q); `CHK(q, ENABLE_RESET)
    apb(EVENT_STATUS_ADDR, 0, 0, 0, q); `CHK(q, STATUS_RESET)
    apb(CONFIG_ADDR, 0, 0, 0, q); `CHK(q, CFG_RST)
    `CHK({irqPin, dsAtt}, 5'h14)
    apb(12'h040, 0, 0, 0, q); `CHK({slvErr, q}, 17'h10000)
    fire(16'hffff); `CHK(irqLevel, 1'b0)
    apb(EVENT_STATUS_ADDR, 0, 0, 0, q); `CHK(q, EVENT_MASK)
    apb(EVENT_STATUS_ADDR, 0, 0, 0, q); `CHK(q, 16'h0)
    apb(ENABLE_CONTROL_ADDR, 1, 16'hffff, 0, q);
    apb(ENABLE_CONTROL_ADDR, 0, 0, 0, q); `CHK(q, EVENT_MASK)
    // one enable at a time: only its own event drives the pin
    for (int b = 0; b < 16; b++) if (EVENT_MASK[b]) begin
      apb(ENABLE_CONTROL_ADDR, 1, 16'h1 << b, 0, q);
      fire(EVENT_MASK & ~(16'h1 << b)); `CHK(irqLevel, 1'b0)
      fire(16'h1 << b); `CHK({irqLevel, irqPin}, 2'b10)
      apb(EVENT_STATUS_ADDR, 0, 0, 0, q); `CHK(q, EVENT_MASK)
    end
    // event in the access cycle of a read survives the clear
    apb(EVENT_STATUS_ADDR, 0, 0, 16'h0001, q);
    apb(EVENT_STATUS_ADDR, 0, 0, 0, q); `CHK(q, 16'h0001)
    // config fields and active-high pin
    apb(CONFIG_ADDR, 1, 16'h0000, 0, q);
    apb(CONFIG_ADDR, 0, 0, 0, q); `CHK({q, dsEn, dsEnh, ds10}, 19'h04038)
    apb(ENABLE_CONTROL_ADDR, 1, 16'h0001, 0, q);
    fire(16'h0001); `CHK({irqLevel, irqPin}, 2'b11)
    apb(CONFIG_ADDR, 1, 16'hffff, 0, q);
    apb(CONFIG_ADDR, 0, 0, 0, q); `CHK({q, dsEn, dsEnh, ds10}, 19'h15a3f)
    end_sim();
  end
endmodule : tb
